// ===== hw/wepc_top.sv
// wake event power control: power management control register and wake pin
// assumes event inputs stay high until the source clears them, all in clk domain
//
// Functional notes
// - port 2 energy event sets status bit 17; write one clears it.
// - port 1 energy event sets status bit 16; write one clears it.
// - write-one clear fails while the source event is still pending.
// - enable bit 15 lets port 2 energy events drive the wake pin.
// - enable bit 14 lets port 1 energy events drive the wake pin.
// - enabled energy events raise the wake interrupt flag regardless of pin enable.
// - writing one to bit 10 resets the virtual phy; clears itself afterwards.
// - writes to bit 10 are ignored while it reads high.
// - enable bit 9 lets lan wake events drive pin and interrupt flag.
// - this register stays readable while not ready; reads get no answer while sys_rst is high.
// - bit 1 gates the wake pin; interrupt flag is not gated.
// - bit 3 clear gives a 50 ms pulse, set holds pin continuously.
// - bit 5 is lan wake status, write one clears once source cleared.
// - bit 0 is read-only ready flag, low after sys_rst.
`timescale 1ns/10ps
`default_nettype none

module wepc_top #(
  parameter int unsigned PULSE_CYCLES = wepc_pkg::WAKE_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire wepc_pkg::wepc_host_req_t host_req,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  input wire wepc_pkg::wepc_evt_t evt_pending,
  input wire logic device_ready,
  input wire logic vphy_in_reset,
  output logic virtual_phy_reset_out,
  output logic wake_event_pin,
  output logic wake_irq_flag
);

  // ==========================================================================
  // register state
  // ==========================================================================
  wepc_pkg::wepc_evt_t seen_q;
  wepc_pkg::wepc_evt_t wake_en_q;
  logic wake_pin_enable_q;
  logic wake_pin_style_q;
  logic ready_q;
  wepc_pkg::wepc_vr_state_t vr_state_q;
  logic [3:0] vr_hold_q;
  logic wake_any_q;
  logic [31:0] host_rdata_q;
  logic host_rvalid_q;
  logic virtual_phy_reset_q;
  logic wake_event_pin_q;
  logic wake_irq_flag_q;

  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] reg_word;
  wepc_pkg::wepc_evt_t w1c_mask;
  wepc_pkg::wepc_evt_t wr_en_val;
  logic wake_any;
  logic pulse_start;
  logic pulse_busy;
  logic vphy_bit;

  // ==========================================================================
  // host decode
  // ==========================================================================
  assign hit = host_req.cs && (host_req.addr == wepc_pkg::OFF_POWER_WAKE_CONTROL);
  assign rd_hit = hit && host_req.re;
  // writes before ready are invalid, so they are dropped
  assign wr_hit = hit && host_req.we && ready_q;

  assign w1c_mask = wepc_pkg::wepc_evt_t'({
    host_req.wdata[wepc_pkg::BIT_LAN_WAKE_SEEN],
    host_req.wdata[wepc_pkg::BIT_ENERGY_SEEN_PORT2],
    host_req.wdata[wepc_pkg::BIT_ENERGY_SEEN_PORT1]
  });

  assign wr_en_val = wepc_pkg::wepc_evt_t'({
    host_req.wdata[wepc_pkg::BIT_LAN_WAKE_ENABLE],
    host_req.wdata[wepc_pkg::BIT_ENERGY_WAKE_EN_PORT2],
    host_req.wdata[wepc_pkg::BIT_ENERGY_WAKE_EN_PORT1]
  });

  // ==========================================================================
  // status flags
  // ==========================================================================
  // sticky status flags for port 1 and port 2 energy and lan wake
  // pending source re-sets flag
  // the set term is or-ed after the clear, so a pending source always wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_q <= '0;
    end else if (wr_hit) begin
      seen_q <= (seen_q & ~w1c_mask) | evt_pending;
    end else begin
      seen_q <= seen_q | evt_pending;
    end
  end

  // ==========================================================================
  // enables
  // ==========================================================================
  // zero after reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_en_q <= '0;
      wake_pin_enable_q <= 1'b0;
      wake_pin_style_q <= 1'b0;
    end else if (wr_hit) begin
      wake_en_q <= wr_en_val;
      wake_pin_enable_q <= host_req.wdata[wepc_pkg::BIT_WAKE_PIN_ENABLE];
      wake_pin_style_q <= host_req.wdata[wepc_pkg::BIT_WAKE_PIN_STYLE];
    end
  end

  // ==========================================================================
  // ready flag
  // ==========================================================================
  // ready low after reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= device_ready;
    end
  end

  // ==========================================================================
  // virtual phy reset sequencer
  // ==========================================================================
  // hold the reset a few cycles, then wait for the phy to report it has left
  // reset; a phy that never reports keeps the bit high, which is visible
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vr_state_q <= wepc_pkg::WEPC_VR_IDLE;
      vr_hold_q <= '0;
    end else begin
      unique case (vr_state_q)
        wepc_pkg::WEPC_VR_IDLE: begin
          if (wr_hit && host_req.wdata[wepc_pkg::BIT_VIRTUAL_PHY_RESET]) begin
            vr_state_q <= wepc_pkg::WEPC_VR_HOLD;
            vr_hold_q <= wepc_pkg::VPHY_RESET_HOLD_CYCLES;
          end
        end
        wepc_pkg::WEPC_VR_HOLD: begin
          if (vr_hold_q == 4'h1) begin
            vr_state_q <= wepc_pkg::WEPC_VR_LEAVE;
          end
          vr_hold_q <= vr_hold_q - 4'h1;
        end
        wepc_pkg::WEPC_VR_LEAVE: begin
          if (!vphy_in_reset) begin
            vr_state_q <= wepc_pkg::WEPC_VR_IDLE;
          end
        end
        default: begin
          vr_state_q <= wepc_pkg::WEPC_VR_IDLE;
          vr_hold_q <= '0;
        end
      endcase
    end
  end

  assign vphy_bit = (vr_state_q != wepc_pkg::WEPC_VR_IDLE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      virtual_phy_reset_q <= 1'b0;
    end else begin
      virtual_phy_reset_q <= (vr_state_q == wepc_pkg::WEPC_VR_HOLD);
    end
  end

  // ==========================================================================
  // wake event combining
  // ==========================================================================
  // or of enabled status
  assign wake_any = |(seen_q & wake_en_q);
  assign pulse_start = wake_any && !wake_any_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_any_q <= 1'b0;
    end else begin
      wake_any_q <= wake_any;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_irq_flag_q <= 1'b0;
    end else begin
      wake_irq_flag_q <= wake_any;
    end
  end

  // ==========================================================================
  // wake pin
  // ==========================================================================
  // 50 ms one-shot
  wepc_pulse_timer u_pulse (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(pulse_start),
    .length(PULSE_CYCLES[wepc_pkg::PULSE_CNT_W-1:0]),
    .busy(pulse_busy)
  );

  // clearing the status or the enable drops the pin in either style
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_event_pin_q <= 1'b0;
    end else begin
      wake_event_pin_q <= wake_pin_enable_q && wake_any && (wake_pin_style_q || pulse_busy);
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  // reserved bits zero
  always_comb begin
    reg_word = wepc_pkg::RESET_POWER_WAKE_CONTROL;
    reg_word[wepc_pkg::BIT_ENERGY_SEEN_PORT2] = seen_q.energy_port2;
    reg_word[wepc_pkg::BIT_ENERGY_SEEN_PORT1] = seen_q.energy_port1;
    reg_word[wepc_pkg::BIT_ENERGY_WAKE_EN_PORT2] = wake_en_q.energy_port2;
    reg_word[wepc_pkg::BIT_ENERGY_WAKE_EN_PORT1] = wake_en_q.energy_port1;
    reg_word[wepc_pkg::BIT_VIRTUAL_PHY_RESET] = vphy_bit;
    reg_word[wepc_pkg::BIT_LAN_WAKE_ENABLE] = wake_en_q.lan_wake;
    reg_word[wepc_pkg::BIT_LAN_WAKE_SEEN] = seen_q.lan_wake;
    reg_word[wepc_pkg::BIT_WAKE_PIN_STYLE] = wake_pin_style_q;
    reg_word[wepc_pkg::BIT_WAKE_PIN_ENABLE] = wake_pin_enable_q;
    reg_word[wepc_pkg::BIT_DEVICE_READY] = ready_q;
  end

  // any selected read answers next cycle; other addresses read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_rdata_q <= '0;
      host_rvalid_q <= 1'b0;
    end else begin
      host_rvalid_q <= host_req.cs && host_req.re;
      host_rdata_q <= rd_hit ? reg_word : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign host_rdata = host_rdata_q;
  assign host_rvalid = host_rvalid_q;
  assign virtual_phy_reset_out = virtual_phy_reset_q;
  assign wake_event_pin = wake_event_pin_q;
  assign wake_irq_flag = wake_irq_flag_q;

endmodule // wepc_top

`default_nettype wire

// ===== pkg/wepc_pkg.sv
// wake event power control: shared constants and carrier types
// assumes a 250 MHz system clock and the host bus carrying byte addresses
package wepc_pkg;

  // ==========================================================================
  // host bus and register map
  // ==========================================================================
  localparam int unsigned ADDR_W = 10;
  localparam logic [ADDR_W-1:0] OFF_POWER_WAKE_CONTROL = 10'h084;
  localparam logic [31:0] RESET_POWER_WAKE_CONTROL = 32'h0000_0000;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned BIT_ENERGY_SEEN_PORT2 = 17;
  localparam int unsigned BIT_ENERGY_SEEN_PORT1 = 16;
  localparam int unsigned BIT_ENERGY_WAKE_EN_PORT2 = 15;
  localparam int unsigned BIT_ENERGY_WAKE_EN_PORT1 = 14;
  localparam int unsigned BIT_VIRTUAL_PHY_RESET = 10;
  localparam int unsigned BIT_LAN_WAKE_ENABLE = 9;
  localparam int unsigned BIT_LAN_WAKE_SEEN = 5;
  localparam int unsigned BIT_WAKE_PIN_STYLE = 3;
  localparam int unsigned BIT_WAKE_PIN_ENABLE = 1;
  localparam int unsigned BIT_DEVICE_READY = 0;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned WAKE_PULSE_MS = 50;
  localparam int unsigned WAKE_PULSE_CYCLES = (CLK_FREQ_HZ / 1000) * WAKE_PULSE_MS;
  localparam int unsigned PULSE_CNT_W = 24;
  localparam logic [3:0] VPHY_RESET_HOLD_CYCLES = 4'h8;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic cs;
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } wepc_host_req_t;

  // one bit per wake source; index order matches the status and enable fields
  typedef struct packed {
    logic lan_wake;
    logic energy_port2;
    logic energy_port1;
  } wepc_evt_t;

  typedef enum logic [1:0] {
    WEPC_VR_IDLE = 2'b00,
    WEPC_VR_HOLD = 2'b01,
    WEPC_VR_LEAVE = 2'b11
  } wepc_vr_state_t;

endpackage

// ===== hw/wepc_pulse_timer.sv
// wake event power control: one-shot pulse timer for the wake pin
// assumes start is a one-cycle pulse in the clk domain
`timescale 1ns/10ps
`default_nettype none

module wepc_pulse_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [wepc_pkg::PULSE_CNT_W-1:0] length,
  output logic busy
);

  logic [wepc_pkg::PULSE_CNT_W-1:0] count_q;

  // a new start reloads, so a fresh event restarts the full pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (start) begin
      count_q <= length;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign busy = (count_q != '0);

endmodule // wepc_pulse_timer

`default_nettype wire

// ===== dv/wepc_top_asserts.sv
// wake event power control: port-level assertions on the top module
// assumes one clk domain and binding into every wepc_top instance
`timescale 1ns/10ps
`default_nettype none

module wepc_top_asserts #(
  parameter int unsigned PULSE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire wepc_pkg::wepc_host_req_t host_req,
  input wire logic [31:0] host_rdata,
  input wire logic host_rvalid,
  input wire wepc_pkg::wepc_evt_t evt_pending,
  input wire logic device_ready,
  input wire logic vphy_in_reset,
  input wire logic virtual_phy_reset_out,
  input wire logic wake_event_pin,
  input wire logic wake_irq_flag
);
  // ==========================================================================
  // helpers
  // ==========================================================================
  logic rd_any;
  logic rd_reg;
  assign rd_any = host_req.cs && host_req.re;
  assign rd_reg = rd_any && (host_req.addr == wepc_pkg::OFF_POWER_WAKE_CONTROL);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_vphy_hold;
    virtual_phy_reset_out [*8];
  endsequence
  sequence s_vphy_done;
    !virtual_phy_reset_out;
  endsequence

  // ==========================================================================
  // properties
  // ==========================================================================
  a_rvalid_on_read: assert property (rd_any |=> host_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_only_read: assert property (!rd_any |=> !host_rvalid)
    else $error("read valid without a read");
  a_rdata_idle_zero: assert property (!rd_reg |=> host_rdata == 32'h0)
    else $error("read data not zero outside a register read");
  a_reserved_read_zero: assert property (rd_reg |=> (host_rdata & 32'hfffc39d4) == 32'h0)
    else $error("reserved bits read nonzero");
  a_ready_low_read: assert property (rd_reg && !$past(device_ready) |=> !host_rdata[0])
    else $error("ready bit high before device ready");
  a_status_port2_set: assert property (
      rd_reg && !$past(sys_rst) && $past(evt_pending.energy_port2) |=> host_rdata[17])
    else $error("port 2 energy status not set");
  a_pin_needs_irq: assert property (wake_event_pin |-> wake_irq_flag)
    else $error("wake pin active without interrupt flag");
  a_vphy_hold_len: assert property ($rose(virtual_phy_reset_out) |-> s_vphy_hold ##1 s_vphy_done)
    else $error("virtual phy reset length wrong");
  a_vphy_bit_high: assert property (rd_reg && virtual_phy_reset_out |=> host_rdata[10])
    else $error("virtual phy reset bit low during reset");
endmodule // wepc_top_asserts

bind wepc_top wepc_top_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
  .evt_pending(evt_pending), .device_ready(device_ready), .vphy_in_reset(vphy_in_reset),
  .virtual_phy_reset_out(virtual_phy_reset_out), .wake_event_pin(wake_event_pin), .wake_irq_flag(wake_irq_flag)
);
`default_nettype wire

// ===== dv/wepc_vphy_model.sv
// wake event power control: virtual phy stand-in
// assumes reset request is a level; phy stays in reset a while after it drops
`timescale 1ns/10ps
`default_nettype none

module wepc_vphy_model #(
  parameter int unsigned LEAVE_CYCLES = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic virtual_phy_reset_out,
  output logic vphy_in_reset
);
  logic [3:0] cnt_q;
  // slow release so the bit must wait for the phy, not just the hold timer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cnt_q <= 4'h0;
    else if (virtual_phy_reset_out) cnt_q <= LEAVE_CYCLES[3:0];
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign vphy_in_reset = virtual_phy_reset_out || (cnt_q != 4'h0);
endmodule // wepc_vphy_model
`default_nettype wire

// ===== dv/wepc_top_bench.sv
// wake event power control: self-checking bench
// assumes a 4 ns clk and a shortened wake pulse
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module wepc_top_bench;
  localparam int unsigned PULSE = 20;
  localparam logic [9:0] REG = wepc_pkg::OFF_POWER_WAKE_CONTROL;
  localparam logic [31:0] EN_T [3] = '{32'h4000, 32'h8000, 32'h0200};
  localparam logic [31:0] ST_T [3] = '{32'h10000, 32'h20000, 32'h0020};
  logic clk;
  logic sys_rst;
  wepc_pkg::wepc_host_req_t host_req;
  logic [31:0] host_rdata;
  logic host_rvalid;
  wepc_pkg::wepc_evt_t evt_pending;
  logic device_ready;
  logic vphy_in_reset;
  logic virtual_phy_reset_out;
  logic wake_event_pin;
  logic wake_irq_flag;
  int error_cnt;
  int cmp_count;
  int n;
  logic [31:0] seed;
  logic [31:0] w;

  wepc_top #(.PULSE_CYCLES(PULSE)) u_dut (.clk(clk), .sys_rst(sys_rst), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .evt_pending(evt_pending), .device_ready(device_ready),
    .vphy_in_reset(vphy_in_reset), .virtual_phy_reset_out(virtual_phy_reset_out),
    .wake_event_pin(wake_event_pin), .wake_irq_flag(wake_irq_flag));
  wepc_vphy_model u_vphy (.clk(clk), .sys_rst(sys_rst), .virtual_phy_reset_out(virtual_phy_reset_out),
    .vphy_in_reset(vphy_in_reset));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // only enables, style and pin enable are writable; ready is set
  function automatic logic [31:0] ctl_exp(logic [31:0] v);
    return (v & 32'h0000c20a) | 32'h1;
  endfunction

  task automatic bus(input logic we, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 host_req = '{cs: 1'b1, we: we, re: !we, addr: a, wdata: d};
    @(posedge clk);
    #1 host_req = '0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(host_rvalid, 1'b1)
    `CHK(host_rdata, e)
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #20000;
    error_cnt++;
    test_done();
  end

  initial begin
    seed = 32'hd1165a1c;
    error_cnt = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    host_req = '0;
    evt_pending = '0;
    device_ready = 1'b0;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(REG, 32'h0);
    wr(REG, 32'h0000c20a);
    rd(REG, 32'h0);
    rd(10'h088, 32'h0);
    device_ready = 1'b1;
    tick(2);
    rd(REG, 32'h1);
    for (int i = 0; i < 8; i++) begin
      w = xs() & ~32'h0000_0400;
      wr(REG, w);
      rd(REG, ctl_exp(w));
    end
    // a write to a neighbouring address must leave the register alone
    wr(10'h088, ~w);
    rd(REG, ctl_exp(w));
    // event inputs stand for phys whose energy powerdown software has set
    // pin gated off: interrupt flag still follows the enabled event
    wr(REG, 32'h0000_8000);
    evt_pending.energy_port2 = 1'b1;
    tick(3);
    `CHK(wake_irq_flag, 1'b1)
    `CHK(wake_event_pin, 1'b0)
    wr(REG, 32'h0002_8000);
    rd(REG, 32'h0002_8001);
    evt_pending.energy_port2 = 1'b0;
    wr(REG, 32'h0002_8000);
    rd(REG, 32'h0000_8001);
    tick(2);
    `CHK(wake_irq_flag, 1'b0)
    wr(REG, 32'h0000_400a);
    evt_pending.energy_port1 = 1'b1;
    tick(30);
    `CHK(wake_event_pin, 1'b1)
    evt_pending.energy_port1 = 1'b0;
    wr(REG, 32'h0001_400a);
    tick(2);
    `CHK(wake_event_pin, 1'b0)
    for (int k = 0; k < 3; k++) begin
      wr(REG, EN_T[k] | 32'h2);
      evt_pending = wepc_pkg::wepc_evt_t'(3'b001 << k);
      n = 0;
      repeat (40) begin
        @(posedge clk);
        #1;
        if (wake_event_pin === 1'b1) n++;
      end
      `CHK(n, PULSE)
      rd(REG, EN_T[k] | ST_T[k] | 32'h3);
      evt_pending = '0;
      wr(REG, ST_T[k]);
      rd(REG, 32'h1);
    end
    wr(REG, 32'h0000_0400);
    rd(REG, 32'h0000_0401);
    `CHK(virtual_phy_reset_out, 1'b1)
    wr(REG, 32'h0000_0000);
    rd(REG, 32'h0000_0401);
    tick(30);
    rd(REG, 32'h0000_0001);
    `CHK(virtual_phy_reset_out, 1'b0)
    wr(REG, 32'h0000_c20a);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    rd(REG, 32'h1);
    test_done();
  end
endmodule // wepc_top_bench
`default_nettype wire
